// *** rtl/pdfs_params.svh ***
// Constants of the port D pin function select block: register map, field layout, codes.
// Assumes inclusion by bare name from any file of the block.
`ifndef PDFS_PARAMS_SVH
`define PDFS_PARAMS_SVH

// Word index of the control register inside the slave's 4 KB window
`define PDFS_CTRL_WORD      10'h000
`define PDFS_CTRL_RESET     16'h0000
`define PDFS_CTRL_EXT_RESET 16'h1111
`define PDFS_CTRL_WMASK     16'h7777
`define PDFS_FIELD_STRIDE   4
`define PDFS_SEL_PORT       3'h0
`define PDFS_SEL_BUS        3'h1
`define PDFS_SEL_TIMER      3'h5
`define PDFS_NPINS          4
// First of the pins with a timer capture function (pin 6, index 2)
`define PDFS_TIMER_FIRST    2
`define PDFS_HTRANS_NONSEQ  2'h2
`define PDFS_HSIZE_BYTE     3'h0
`define PDFS_HSIZE_HALF     3'h1

`endif

// *** rtl/pdfs_pkg.sv ***
// Types shared by the port D pin function select block.
// Assumes nothing beyond a SystemVerilog compiler.
package pdfs_pkg;
	typedef logic [2:0] pdfs_sel_t;
	typedef enum logic [1:0] {PDFS_OWN_PORT, PDFS_OWN_BUS, PDFS_OWN_TIMER} pdfs_owner_t;
endpackage : pdfs_pkg

// *** rtl/pdfs_route_if.sv ***
// Carrier between the register block and the per-pin owner decoder.
// Assumes pdfs_pkg is compiled first.
`timescale 1ns/1ps
interface pdfs_route_if;
	pdfs_pkg::pdfs_sel_t   sel   [4];
	pdfs_pkg::pdfs_owner_t owner [4];
	modport ctrl (output sel, input owner);
	modport dec  (input sel, output owner);
endinterface : pdfs_route_if

// *** rtl/pdfs_owner_dec.sv ***
// Decodes each pin's mode field into the owner of that pin.
// Assumes the fields arrive from a register; purely combinational.
`timescale 1ns/1ps
`include "pdfs_params.svh"
module pdfs_owner_dec (
	pdfs_route_if.dec rt
);
	genvar g;
	generate
		for (g = 0; g < `PDFS_NPINS; g++) begin : g_pin
			always_comb begin
				// Prohibited codes fall back to the port: the pin never floats into a stray owner
				if (rt.sel[g] == `PDFS_SEL_BUS) begin
					rt.owner[g] = pdfs_pkg::PDFS_OWN_BUS;
				end else if (rt.sel[g] == `PDFS_SEL_TIMER && g >= `PDFS_TIMER_FIRST) begin
					rt.owner[g] = pdfs_pkg::PDFS_OWN_TIMER;
				end else begin
					rt.owner[g] = pdfs_pkg::PDFS_OWN_PORT;
				end
			end
		end
	endgenerate
endmodule : pdfs_owner_dec

// *** rtl/pdfs_pin_select.sv ***
// Top of the port D pin function select: AHB-Lite control register and pin routing for pins 7..4.
// Assumes one 20 MHz clock, all inputs synchronous to it, a single AHB-Lite master.
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pdfs_params.svh"
// How it works
// - Reserved bits 15, 11, 7, 3 read zero; writes to them are dropped.
// - Pin 7 field bits 14..12: 000 routes port, 001 routes bus data bit 7.
// - Pin 7 code 101 feeds the W-phase timer capture; other codes prohibited.
// - Pin 6 field bits 10..8: 000 port, 001 bus data bit 6, 101 V capture.
// - Register resets to zero; external boot mode sets each field's low bit.
module pdfs_pin_select (
	input  wire  logic        mclk,
	input  wire  logic        rst_n,
	input  wire  logic        boot_ext_mode,
	input  wire  logic        hsel,
	input  wire  logic [31:0] haddr,
	input  wire  logic [1:0]  htrans,
	input  wire  logic        hwrite,
	input  wire  logic [2:0]  hsize,
	input  wire  logic [31:0] hwdata,
	input  wire  logic        hready,
	output logic       [31:0] hrdata,
	output logic              hreadyout,
	output logic              hresp,
	input  wire  logic [3:0]  pin_in,
	output logic       [3:0]  pin_out,
	output logic       [3:0]  pin_oe,
	input  wire  logic [3:0]  port_out,
	input  wire  logic [3:0]  port_oe,
	output logic       [3:0]  port_in,
	input  wire  logic [3:0]  bus_data_out,
	input  wire  logic        bus_data_oe,
	output logic       [3:0]  bus_data_in,
	output logic              timer_capture_w_input,
	output logic              timer_capture_v_input
);
	logic [15:0] ctrl_q, ctrl_d;
	logic        init_done_q, init_done_d;
	logic        wr_pend_q, wr_pend_d;
	logic [1:0]  lane_q, lane_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic        hready_q;
	logic        hresp_q;
	logic [3:0]  pin_out_d, pin_oe_d, port_in_d, bus_in_d;
	logic        cap_w_d, cap_v_d;
	logic        addr_ok, addr_hit;

	pdfs_route_if rt ();

	pdfs_owner_dec u_dec (
		.rt (rt.dec)
	);

	genvar g;
	generate
		for (g = 0; g < `PDFS_NPINS; g++) begin : g_sel
			assign rt.sel[g] = ctrl_q[g*`PDFS_FIELD_STRIDE +: 3];
		end
	endgenerate

	// Bus front end and control register
	assign addr_ok  = hsel && hready && htrans == `PDFS_HTRANS_NONSEQ;
	assign addr_hit = haddr[11:2] == `PDFS_CTRL_WORD;

	always_comb begin
		ctrl_d      = ctrl_q;
		init_done_d = 1'b1;
		wr_pend_d   = 1'b0;
		lane_d      = 2'h0;
		hrdata_d    = hrdata_q;
		// The boot strap is taken on the first edge after release, never by the reset itself
		if (!init_done_q) begin
			ctrl_d = boot_ext_mode ? `PDFS_CTRL_EXT_RESET : `PDFS_CTRL_RESET;
		end
		if (wr_pend_q) begin
			if (lane_q[0]) begin
				ctrl_d[7:0] = hwdata[7:0] & 8'(`PDFS_CTRL_WMASK);
			end
			if (lane_q[1]) begin
				ctrl_d[15:8] = hwdata[15:8] & 8'(`PDFS_CTRL_WMASK >> 8);
			end
		end
		if (addr_ok) begin
			if (hwrite) begin
				wr_pend_d = addr_hit;
				lane_d[0] = hsize > `PDFS_HSIZE_HALF || (!haddr[1] && (hsize == `PDFS_HSIZE_HALF || !haddr[0]));
				lane_d[1] = hsize > `PDFS_HSIZE_HALF || (!haddr[1] && (hsize == `PDFS_HSIZE_HALF || haddr[0]));
			end else begin
				// Read of the next value so a read right behind a write sees that write
				hrdata_d = addr_hit ? {16'h0000, ctrl_d & `PDFS_CTRL_WMASK} : 32'h0000_0000;
			end
		end
	end

	// Pin routing; outputs are registered, so a new field takes effect one cycle after it lands
	always_comb begin
		pin_out_d = '0;
		pin_oe_d  = '0;
		port_in_d = '0;
		bus_in_d  = '0;
		for (int i = 0; i < `PDFS_NPINS; i++) begin
			unique case (rt.owner[i])
				pdfs_pkg::PDFS_OWN_PORT: begin
					pin_out_d[i] = port_out[i];
					pin_oe_d[i]  = port_oe[i];
					port_in_d[i] = pin_in[i];
				end
				pdfs_pkg::PDFS_OWN_BUS: begin
					pin_out_d[i] = bus_data_out[i];
					pin_oe_d[i]  = bus_data_oe;
					bus_in_d[i]  = pin_in[i];
				end
				pdfs_pkg::PDFS_OWN_TIMER: begin
					pin_out_d[i] = 1'b0;
					pin_oe_d[i]  = 1'b0;
				end
			endcase
		end
		cap_w_d = rt.owner[3] == pdfs_pkg::PDFS_OWN_TIMER && pin_in[3];
		cap_v_d = rt.owner[2] == pdfs_pkg::PDFS_OWN_TIMER && pin_in[2];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q                <= `PDFS_CTRL_RESET;
			init_done_q           <= 1'b0;
			wr_pend_q             <= 1'b0;
			lane_q                <= 2'h0;
			hrdata_q              <= 32'h0000_0000;
			hready_q              <= 1'b1;
			hresp_q               <= 1'b0;
			pin_out               <= 4'h0;
			pin_oe                <= 4'h0;
			port_in               <= 4'h0;
			bus_data_in           <= 4'h0;
			timer_capture_w_input <= 1'b0;
			timer_capture_v_input <= 1'b0;
		end else begin
			ctrl_q                <= ctrl_d;
			init_done_q           <= init_done_d;
			wr_pend_q             <= wr_pend_d;
			lane_q                <= lane_d;
			hrdata_q              <= hrdata_d;
			hready_q              <= 1'b1;
			hresp_q               <= 1'b0;
			pin_out               <= pin_out_d;
			pin_oe                <= pin_oe_d;
			port_in               <= port_in_d;
			bus_data_in           <= bus_in_d;
			timer_capture_w_input <= cap_w_d;
			timer_capture_v_input <= cap_v_d;
		end
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = hready_q;
	assign hresp     = hresp_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_resv_bits_zero: assert property (hrdata[31:16] == 16'h0 && (ctrl_q & ~`PDFS_CTRL_WMASK) == 16'h0
		&& hrdata[15] == 1'b0 && hrdata[11] == 1'b0 && hrdata[7] == 1'b0 && hrdata[3] == 1'b0)
		else $error("reserved bit not zero");
	// Port checks skip the release edges: outputs still hold reset values there while the field reads port
	a_pin7_port_drive: assert property (init_done_q && ctrl_q[14:12] == `PDFS_SEL_PORT |=>
		pin_out[3] == $past(port_out[3]) && pin_oe[3] == $past(port_oe[3]))
		else $error("pin 7 port route wrong");
	a_pin7_bus_drive: assert property (ctrl_q[14:12] == `PDFS_SEL_BUS |=>
		pin_out[3] == $past(bus_data_out[3]) && bus_data_in[3] == $past(pin_in[3]))
		else $error("pin 7 bus route wrong");
	a_pin7_timer_in: assert property (ctrl_q[14:12] == `PDFS_SEL_TIMER |=>
		timer_capture_w_input == $past(pin_in[3]) && !pin_oe[3])
		else $error("pin 7 capture route wrong");
	a_pin6_timer_in: assert property (ctrl_q[10:8] == `PDFS_SEL_TIMER |=>
		timer_capture_v_input == $past(pin_in[2]) && !pin_oe[2] && port_in[2] == 1'b0)
		else $error("pin 6 capture route wrong");
	a_pin6_bus_drive: assert property (ctrl_q[10:8] == `PDFS_SEL_BUS |=>
		pin_out[2] == $past(bus_data_out[2]) && !timer_capture_v_input)
		else $error("pin 6 bus route wrong");
	a_boot_load: assert property ($rose(init_done_q) |->
		ctrl_q == ($past(boot_ext_mode) ? `PDFS_CTRL_EXT_RESET : `PDFS_CTRL_RESET))
		else $error("boot value not loaded");
	a_word_write_lands: assert property (init_done_q && addr_ok && hwrite && addr_hit && hsize == 3'h2 ##1 1'b1 |=>
		ctrl_q == ($past(hwdata[15:0]) & `PDFS_CTRL_WMASK))
		else $error("word write not stored");
	a_pin6_port_drive: assert property (init_done_q && ctrl_q[10:8] == `PDFS_SEL_PORT |=>
		pin_out[2] == $past(port_out[2]) && port_in[2] == $past(pin_in[2]) && bus_data_in[2] == 1'b0)
		else $error("pin 6 port route wrong");
	// Prohibited codes must leave the pin with the port, never with a stray owner
	a_pin7_prohibited: assert property (ctrl_q[14:13] != 2'b00 && ctrl_q[14:12] != `PDFS_SEL_TIMER |=>
		pin_oe[3] == $past(port_oe[3]) && port_in[3] == $past(pin_in[3]) && !timer_capture_w_input)
		else $error("pin 7 prohibited code not on port");
	a_pin6_prohibited: assert property (ctrl_q[10:9] != 2'b00 && ctrl_q[10:8] != `PDFS_SEL_TIMER |=>
		pin_oe[2] == $past(port_oe[2]) && port_in[2] == $past(pin_in[2]) && !timer_capture_v_input)
		else $error("pin 6 prohibited code not on port");
	a_cap_w_idle: assert property (ctrl_q[14:12] != `PDFS_SEL_TIMER |=> !timer_capture_w_input)
		else $error("pin 7 capture active off timer code");
	a_cap_v_idle: assert property (ctrl_q[10:8] != `PDFS_SEL_TIMER |=> !timer_capture_v_input)
		else $error("pin 6 capture active off timer code");
	a_pin5_bus_drive: assert property (ctrl_q[6:4] == `PDFS_SEL_BUS |=>
		pin_out[1] == $past(bus_data_out[1]) && pin_oe[1] == $past(bus_data_oe))
		else $error("pin 5 bus route wrong");
	a_pin5_port_drive: assert property (init_done_q && ctrl_q[6:4] == `PDFS_SEL_PORT |=>
		pin_out[1] == $past(port_out[1]) && pin_oe[1] == $past(port_oe[1]))
		else $error("pin 5 port route wrong");
	a_pin4_bus_drive: assert property (ctrl_q[2:0] == `PDFS_SEL_BUS |=>
		pin_out[0] == $past(bus_data_out[0]) && bus_data_in[0] == $past(pin_in[0]))
		else $error("pin 4 bus route wrong");
	a_pin4_timer_port: assert property (ctrl_q[2:0] == `PDFS_SEL_TIMER |=>
		pin_out[0] == $past(port_out[0]) && port_in[0] == $past(pin_in[0]))
		else $error("pin 4 timer code not on port");
	a_unmapped_read_zero: assert property (addr_ok && !hwrite && !addr_hit |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_read_returns_reg: assert property (addr_ok && !hwrite && addr_hit |=>
		hrdata == {16'h0000, ctrl_q})
		else $error("read data not the register");
	a_hold_no_write: assert property (init_done_q && !wr_pend_q |=> $stable(ctrl_q))
		else $error("register changed without a write");

	c_write_then_read: cover property (wr_pend_q ##2 addr_ok && !hwrite);
	c_pin7_timer: cover property (ctrl_q[14:12] == `PDFS_SEL_TIMER ##1 timer_capture_w_input);
	c_ext_boot: cover property ($rose(init_done_q) && ctrl_q == `PDFS_CTRL_EXT_RESET);
	c_unmapped_read: cover property (addr_ok && !hwrite && !addr_hit);
	c_pin7_bus: cover property (ctrl_q[14:12] == `PDFS_SEL_BUS ##1 bus_data_in[3]);
endmodule : pdfs_pin_select

// *** verification/pdfs_pin_select_tb_top.sv ***
// Self-checking bench for the port D pin function select: register access over AHB-Lite and pin routing.
// Assumes the design's zero-wait-state slave, one master, and mclk at 20 MHz.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
	$display("BAD %0t got %h expected %h", $time, (a), (b)); end end
module pdfs_pin_select_tb_top;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        boot_ext_mode = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp;
	logic [3:0]  pin_in = 4'h9, pin_out, pin_oe, port_in, bus_data_in;
	logic [3:0]  port_out = 4'ha, port_oe = 4'h5, bus_data_out = 4'h6;
	logic        bus_data_oe = 1'b1;
	logic        timer_capture_w_input, timer_capture_v_input;
	int          num_errors = 0;
	int          checks = 0;
	int          cyc = 0;
	logic [31:0] rdat;
	always #25 mclk = ~mclk;
	pdfs_pin_select i_pdfs_pin_select (.mclk(mclk), .rst_n(rst_n), .boot_ext_mode(boot_ext_mode), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .port_out(port_out), .port_oe(port_oe), .port_in(port_in), .bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe), .bus_data_in(bus_data_in), .timer_capture_w_input(timer_capture_w_input),
		.timer_capture_v_input(timer_capture_v_input));
	task give_verdict;
		if (num_errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	// Whole run needs well under a thousand cycles; the ceiling only cuts a hung handshake
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			give_verdict();
		end
	end
	task do_reset(input logic b);
		@(posedge mclk);
		rst_n <= 1'b0;
		boot_ext_mode <= b;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
	endtask : do_reset
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		r = hrdata;
		`CHK(hresp, 1'b0)
		`CHK(hreadyout, 1'b1)
	endtask : bus
	// Pins 7 and 6 know the timer code; on pins 5 and 4 it falls back to the port
	task chk_pins(input logic [2:0] c);
		logic       b, t;
		logic [3:0] oe, dv;
		// Outputs are looked at mid-cycle, well away from the edge that launches them
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		b = (c == 3'h1);
		t = (c == 3'h5);
		oe = b ? {4{bus_data_oe}} : t ? {2'b00, port_oe[1:0]} : port_oe;
		dv = b ? bus_data_out : t ? {2'b00, port_out[1:0]} : port_out;
		`CHK(pin_oe, oe)
		`CHK(pin_out, dv)
		`CHK(port_in, b ? 4'h0 : t ? {2'b00, pin_in[1:0]} : pin_in)
		`CHK(bus_data_in, b ? pin_in : 4'h0)
		`CHK({timer_capture_w_input, timer_capture_v_input}, t ? pin_in[3:2] : 2'b00)
	endtask : chk_pins
	task test_reset_plain;
		do_reset(1'b0);
		bus(1'b0, 32'h0, 32'h0, rdat);
		`CHK(rdat, 32'h0000_0000)
		chk_pins(3'h0);
	endtask : test_reset_plain
	// Every code, prohibited ones included, is stored as written
	task test_all_codes;
		for (int c = 0; c < 8; c++) begin
			@(posedge mclk);
			pin_in <= 4'h9 + 4'(c);
			bus(1'b1, 32'h0, {16'h0, 1'b0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c)}, rdat);
			chk_pins(3'(c));
			bus(1'b0, 32'h0, 32'h0, rdat);
			`CHK(rdat, {16'h0, 1'b0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c)})
		end
	endtask : test_all_codes
	task test_reserved_unmapped;
		bus(1'b1, 32'h0, 32'hffff_ffff, rdat);
		bus(1'b0, 32'h0, 32'h0, rdat);
		`CHK(rdat, 32'h0000_7777)
		bus(1'b1, 32'h4, 32'h0, rdat);
		bus(1'b0, 32'h4, 32'h0, rdat);
		`CHK(rdat, 32'h0)
		bus(1'b0, 32'h0, 32'h0, rdat);
		`CHK(rdat, 32'h0000_7777)
	endtask : test_reserved_unmapped
	task test_boot_ext;
		do_reset(1'b1);
		bus(1'b0, 32'h0, 32'h0, rdat);
		`CHK(rdat, 32'h0000_1111)
		chk_pins(3'h1);
		// The bus controller's own enable must reach the pins, not a constant
		@(posedge mclk);
		bus_data_oe <= 1'b0;
		chk_pins(3'h1);
	endtask : test_boot_ext
	initial begin
		test_reset_plain();
		test_all_codes();
		test_reserved_unmapped();
		test_boot_ext();
		give_verdict();
	end
endmodule : pdfs_pin_select_tb_top
